// file: core/frw_cfg.svh
`ifndef FRW_CFG_SVH
`define FRW_CFG_SVH
// ==========================================
// command codes of the warning thresholds
`define FRW_REG_OV_WARN   8'h42
`define FRW_REG_UV_WARN   8'h43
// ==========================================
// reset values, linear format, exponent -11
`define FRW_OV_WARN_RST   16'hFFFF
`define FRW_UV_WARN_RST   16'h0000
// ==========================================
// response byte fields, and the read value of an unmapped address
`define FRW_MODE_LSB      6
`define FRW_RETRY_LSB     3
`define FRW_DLY_LSB       0
`define FRW_RETRY_NONE    3'h0
`define FRW_RETRY_FOREVER 3'h7
`define FRW_RD_UNMAPPED   16'h0000
`endif

// file: core/frw_pkg.sv
`default_nettype none
package frw_pkg;
    typedef enum logic [1:0] {
        FRW_IGNORE,
        FRW_CONT_THEN_RETRY,
        FRW_DISABLE_RETRY,
        FRW_DISABLE_WHILE_FAULT
    } frw_mode_t;

    typedef enum {
        ST_RUN,
        ST_CONT,
        ST_OFF_WAIT,
        ST_ATTEMPT,
        ST_HOLD,
        ST_LATCHED
    } frw_state_t;
endpackage : frw_pkg
`default_nettype wire

// file: core/frw_dly_timer.sv
`default_nettype none
module frw_dly_timer #(
    parameter int UNIT_W = 16
) (
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    // control
    input  wire logic              i_start,
    input  wire logic [2:0]        i_code,
    input  wire logic [UNIT_W-1:0] i_unit,
    // status
    output logic                   o_busy,
    output logic                   o_done
);
    localparam int TW = UNIT_W + 8;

    logic [TW-1:0] units;
    logic [TW-1:0] total;
    logic [TW-1:0] cnt_r;
    logic          busy_r;

    // a zero unit would never expire, so it acts as a unit of 1
    assign units  = TW'(1) << i_code;
    assign total  = units * ((i_unit == '0) ? TW'(1) : TW'(i_unit));
    assign o_busy = busy_r;
    assign o_done = busy_r && (cnt_r == '0);

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
        end else if (i_ce) begin
            if (i_start) begin
                cnt_r  <= total - TW'(1);
                busy_r <= 1'b1;
            end else if (o_done) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - TW'(1);
            end
        end
    end

    // ==========================================
    // checks
    load_period_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && i_start) |=> (cnt_r == $past(total) - TW'(1)) && busy_r)
        else $error("timer loaded wrong period");
endmodule : frw_dly_timer
`default_nettype wire

// file: core/frw_top.sv
`include "frw_cfg.svh"
`default_nettype none
module frw_top
    import frw_pkg::*;
#(
    parameter int UNIT_W = 16
) (
    // clock, reset, enable
    input  wire logic              i_sys_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_ce,
    // fault response configuration
    input  wire logic [7:0]        i_fault_resp,
    input  wire logic [UNIT_W-1:0] i_delay_unit,
    // fault and control events
    input  wire logic              i_fault,
    input  wire logic              i_other_fault,
    input  wire logic              i_output_cmd_on,
    input  wire logic              i_clear_bit,
    input  wire logic              i_clear_faults,
    input  wire logic              i_bias_lost,
    // threshold register access
    input  wire logic              i_reg_wr,
    input  wire logic [7:0]        i_reg_addr,
    input  wire logic [15:0]       i_reg_wdata,
    output logic      [15:0]       o_reg_rdata,
    // measured output voltage
    input  wire logic [15:0]       i_vout,
    // status
    output logic                   o_output_en,
    output logic                   o_fault_latched,
    output logic [2:0]             o_attempts,
    output logic                   o_ov_warn,
    output logic                   o_uv_warn
);
    frw_mode_t  mode;
    logic [2:0] retry_code;
    logic [2:0] dly_code;
    frw_state_t state_r;
    frw_state_t state_nxt;
    logic [2:0] attempts_r;
    logic [2:0] attempts_nxt;
    logic       att_fail_r;
    logic       tmr_start;
    logic       tmr_done;
    logic       clr;
    logic       limit_hit;
    logic [15:0] ov_lim_r;
    logic [15:0] uv_lim_r;

    assign mode       = frw_mode_t'(i_fault_resp[`FRW_MODE_LSB +: 2]);
    assign retry_code = i_fault_resp[`FRW_RETRY_LSB +: 3];
    assign dly_code   = i_fault_resp[`FRW_DLY_LSB +: 3];
    // commanded off also counts as a clear, so off-then-on restarts clean
    assign clr = i_clear_bit | i_clear_faults | i_bias_lost | ~i_output_cmd_on;
    assign limit_hit = (retry_code != `FRW_RETRY_FOREVER)
                       && (attempts_r >= retry_code);

    // ==========================================
    // delay timer, shared by continue time and restart spacing
    frw_dly_timer #(
        .UNIT_W (UNIT_W)
    ) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst),
        .i_ce      (i_ce),
        .i_start   (tmr_start),
        .i_code    (dly_code),
        .i_unit    (i_delay_unit),
        .o_busy    (),
        .o_done    (tmr_done)
    );

    // ==========================================
    // sequencer next state
    always_comb begin
        state_nxt    = state_r;
        attempts_nxt = attempts_r;
        tmr_start    = 1'b0;
        if (clr) begin
            state_nxt    = ST_RUN;
            attempts_nxt = 3'h0;
        end else if (i_other_fault) begin
            state_nxt = ST_LATCHED;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (i_fault) begin
                        unique case (mode)
                            FRW_IGNORE: state_nxt = ST_RUN;
                            FRW_CONT_THEN_RETRY: begin
                                state_nxt = ST_CONT;
                                tmr_start = 1'b1;
                            end
                            FRW_DISABLE_RETRY: begin
                                // no restart at all for code 000
                                state_nxt = (retry_code == `FRW_RETRY_NONE) ?
                                            ST_LATCHED : ST_OFF_WAIT;
                                tmr_start = 1'b1;
                            end
                            FRW_DISABLE_WHILE_FAULT: state_nxt = ST_HOLD;
                        endcase
                    end
                end
                ST_CONT: begin
                    if (tmr_done) begin
                        if (!i_fault) begin
                            state_nxt = ST_RUN;
                        end else begin
                            state_nxt = (retry_code == `FRW_RETRY_NONE) ?
                                        ST_LATCHED : ST_OFF_WAIT;
                            tmr_start = 1'b1;
                        end
                    end
                end
                ST_OFF_WAIT: begin
                    if (tmr_done) begin
                        state_nxt    = ST_ATTEMPT;
                        tmr_start    = 1'b1;
                        attempts_nxt = attempts_r + 3'h1;
                    end
                end
                ST_ATTEMPT: begin
                    if (tmr_done) begin
                        if (!att_fail_r && !i_fault) begin
                            state_nxt    = ST_RUN;
                            attempts_nxt = 3'h0;
                        end else if (limit_hit) begin
                            state_nxt = ST_LATCHED;
                        end else begin
                            // next attempt starts one full interval after the last
                            tmr_start = 1'b1;
                            if (retry_code != `FRW_RETRY_FOREVER) begin
                                attempts_nxt = attempts_r + 3'h1;
                            end
                        end
                    end
                end
                ST_HOLD: begin
                    if (!i_fault) begin
                        state_nxt = ST_RUN;
                    end
                end
                ST_LATCHED: state_nxt = ST_LATCHED;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r    <= ST_RUN;
            attempts_r <= 3'h0;
        end else if (i_ce) begin
            state_r    <= state_nxt;
            attempts_r <= attempts_nxt;
        end
    end

    // a failed attempt drops the output but keeps the spacing running
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            att_fail_r <= 1'b0;
        end else if (i_ce) begin
            if (tmr_start || state_nxt != ST_ATTEMPT) begin
                att_fail_r <= 1'b0;
            end else if (state_r == ST_ATTEMPT && i_fault) begin
                att_fail_r <= 1'b1;
            end
        end
    end

    // ==========================================
    // status outputs
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_output_en     <= 1'b0;
            o_fault_latched <= 1'b0;
            o_attempts      <= 3'h0;
        end else if (i_ce) begin
            o_output_en <= i_output_cmd_on && !clr
                           && (state_nxt == ST_RUN || state_nxt == ST_CONT
                               || (state_nxt == ST_ATTEMPT && !i_fault));
            o_fault_latched <= (state_nxt == ST_LATCHED);
            o_attempts      <= attempts_nxt;
        end
    end

    // ==========================================
    // warning thresholds
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ov_lim_r <= `FRW_OV_WARN_RST;
            uv_lim_r <= `FRW_UV_WARN_RST;
        end else if (i_ce && i_reg_wr) begin
            if (i_reg_addr == `FRW_REG_OV_WARN) begin
                ov_lim_r <= i_reg_wdata;
            end
            if (i_reg_addr == `FRW_REG_UV_WARN) begin
                uv_lim_r <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata <= `FRW_RD_UNMAPPED;
        end else if (i_ce) begin
            unique case (i_reg_addr)
                `FRW_REG_OV_WARN: o_reg_rdata <= ov_lim_r;
                `FRW_REG_UV_WARN: o_reg_rdata <= uv_lim_r;
                default:          o_reg_rdata <= `FRW_RD_UNMAPPED;
            endcase
        end
    end

    // flags only; the sequencer never looks at them
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_ov_warn <= 1'b0;
            o_uv_warn <= 1'b0;
        end else if (i_ce) begin
            o_ov_warn <= (i_vout > ov_lim_r);
            o_uv_warn <= (i_vout < uv_lim_r);
        end
    end

    // ==========================================
    // checks
    sequence s_attempt_fails;
        i_ce && !clr && !i_other_fault && state_r == ST_ATTEMPT && tmr_done
        && (att_fail_r || i_fault);
    endsequence

    attempt_limit_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (retry_code != `FRW_RETRY_FOREVER) |-> attempts_r <= retry_code)
        else $error("more attempts than the retry code allows");

    latched_off_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        o_fault_latched |-> !o_output_en)
        else $error("output enabled while latched off");

    forever_retry_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (s_attempt_fails and retry_code == `FRW_RETRY_FOREVER)
        |=> state_r == ST_ATTEMPT)
        else $error("continuous retry stopped");

    final_fail_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (s_attempt_fails and limit_hit) |=> state_r == ST_LATCHED && !o_output_en)
        else $error("exhausted retries did not latch off");

    cont_recover_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && !clr && !i_other_fault && state_r == ST_CONT && tmr_done && !i_fault)
        |=> state_r == ST_RUN)
        else $error("continue mode did not resume");

    no_retry_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && !clr && !i_other_fault && state_r == ST_RUN && i_fault
         && mode == FRW_DISABLE_RETRY && retry_code == `FRW_RETRY_NONE)
        |=> o_fault_latched ##1 (o_fault_latched || $past(clr)))
        else $error("code 000 did not latch off");

    clear_faults_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && clr) |=> !o_fault_latched && attempts_r == 3'h0)
        else $error("clear did not release the fault");

    ov_warn_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && i_vout > ov_lim_r) |=> o_ov_warn)
        else $error("over-voltage warning missed");

    restart_ok_a : assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
        (i_ce && !clr && !i_other_fault && state_r == ST_ATTEMPT && tmr_done
         && !att_fail_r && !i_fault) |=> attempts_r == 3'h0)
        else $error("attempt count not reset after restart");
endmodule : frw_top
`default_nettype wire

// file: bench/frw_host_model.sv
`default_nettype none
module frw_host_model (
    // clock
    input  wire logic        i_sys_clk,
    // register port towards the device
    output logic             o_reg_wr,
    output logic [7:0]       o_reg_addr,
    output logic [15:0]      o_reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_reg_wr    = 1'b0;
        o_reg_addr  = 8'h00;
        o_reg_wdata = 16'h0000;
    end
    // ==========================================
    // word write, strobe held for one edge only
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b1;
        o_reg_addr  <= a;
        o_reg_wdata <= d;
        @(posedge i_sys_clk);
        o_reg_wr    <= 1'b0;
        o_reg_wdata <= ~d; // stale data is never left on the bus
    endtask : write_word
    task automatic point_at(input logic [7:0] a);
        @(posedge i_sys_clk);
        o_reg_addr <= a;
    endtask : point_at
endmodule : frw_host_model
`default_nettype wire

// file: bench/test_fault_retry_and_vout_warn_limits.sv
`default_nettype none
module test_fault_retry_and_vout_warn_limits
    import frw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int sel; logic [15:0] exp;} frw_note_t;
    logic clk, rst, ce, fault, oth, cmd_on, clr_bit, clr_all, bias;
    logic wr, en, lat, ov, uv;
    logic [7:0]  resp, addr;
    logic [15:0] unit, wdata, rdata, vout, gap_seen, w, t;
    logic [2:0]  att;
    frw_note_t   q[$];
    event        chk_ev;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'h999AD753;
    int n;
    string nm[7] = '{"rdata", "output_en", "latched", "attempts", "ov_warn", "uv_warn", "gap"};

    frw_top #(.UNIT_W(16)) uut (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_ce(ce), .i_fault_resp(resp),
        .i_delay_unit(unit), .i_fault(fault), .i_other_fault(oth),
        .i_output_cmd_on(cmd_on), .i_clear_bit(clr_bit), .i_clear_faults(clr_all),
        .i_bias_lost(bias), .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .o_reg_rdata(rdata), .i_vout(vout), .o_output_en(en), .o_fault_latched(lat),
        .o_attempts(att), .o_ov_warn(ov), .o_uv_warn(uv));
    frw_host_model host (.i_sys_clk(clk), .o_reg_wr(wr), .o_reg_addr(addr),
        .o_reg_wdata(wdata));

    // ==========================================
    // clock, watchdog, verdict
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (30000) @(posedge clk);
        err_count++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        end_of_test();
    end
    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // ==========================================
    // monitor: oldest note against the output now
    function automatic logic [15:0] got(input int s);
        case (s)
            0: return rdata;
            1: return 16'(en);
            2: return 16'(lat);
            3: return 16'(att);
            4: return 16'(ov);
            5: return 16'(uv);
            default: return gap_seen;
        endcase
    endfunction : got
    initial forever begin
        @(chk_ev);
        while (q.size() > 0) begin
            frw_note_t c;
            c = q.pop_front();
            samples_checked++;
            if (got(c.sel) !== c.exp) begin
                err_count++;
                $display("CHECK FAILED %s expected %h seen %h", nm[c.sel], c.exp, got(c.sel));
            end
        end
    end

    // ==========================================
    // driver helpers
    task automatic note(input int s, input logic [15:0] e);
        q.push_back('{s, e});
        ->chk_ev;
    endtask : note
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // a miss within the bound shows up as a mismatch
    task automatic wait_for(input int s, input logic [15:0] e, input int lim);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (got(s) !== e && n < lim);
        note(s, e);
    endtask : wait_for
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.point_at(a);
        tick(1);
        note(0, e);
    endtask : rd
    task automatic arm(input logic [1:0] m, input logic [2:0] r, input logic [2:0] d,
                       input logic [15:0] u);
        @(posedge clk);
        resp <= {m, r, d};
        unit <= u;
    endtask : arm
    task automatic set_fault(input logic v);
        @(posedge clk);
        fault <= v;
    endtask : set_fault

    // ==========================================
    // main sequence
    initial begin
        rst = 1'b1; ce = 1'b1; fault = 1'b0; oth = 1'b0; cmd_on = 1'b1;
        clr_bit = 1'b0; clr_all = 1'b0; bias = 1'b0;
        resp = 8'h00; unit = 16'h0002; vout = 16'h0000; gap_seen = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(8'h42, 16'hFFFF);
        rd(8'h43, 16'h0000);
        w = 16'($random(seed)) & 16'h7FFF | 16'h0100;
        host.write_word(8'h42, w);
        host.write_word(8'h43, w - 16'h0080);
        host.write_word(8'h44, w);
        rd(8'h42, w);
        rd(8'h43, w - 16'h0080);
        rd(8'h44, 16'h0000);
        @(posedge clk);
        ce <= 1'b0;
        host.write_word(8'h42, ~w);
        @(posedge clk);
        ce <= 1'b1;
        rd(8'h42, w);
        // warning flags never touch the output
        @(posedge clk);
        vout <= w + 16'h0001;
        tick(1);
        note(4, 16'h0001);
        note(5, 16'h0000);
        note(1, 16'h0001);
        @(posedge clk);
        vout <= w;
        tick(1);
        note(4, 16'h0000);
        @(posedge clk);
        vout <= w - 16'h0081;
        tick(1);
        note(5, 16'h0001);
        note(1, 16'h0001);
        for (int r = 0; r < 7; r++) begin
            arm(2'b10, r[2:0], 3'h0, 16'h0002);
            set_fault(1'b1);
            wait_for(2, 16'h0001, 2 * r + 4);
            note(3, 16'(r));
            tick(5);
            note(1, 16'h0000);
            note(2, 16'h0001);
            set_fault(1'b0);
            @(posedge clk);
            clr_all <= 1'b1;
            @(posedge clk);
            clr_all <= 1'b0;
            wait_for(2, 16'h0000, 3);
            note(3, 16'h0000);
        end
        // spacing from random delay code and unit
        for (int k = 0; k < 3; k++) begin
            t = 16'($random(seed)) & 16'h0007;
            w = 16'(($random(seed) & 3) + 1);
            arm(2'b10, 3'h3, t[2:0], w);
            t = (16'h0001 << t) * w;
            set_fault(1'b1);
            wait_for(3, 16'h0001, 1000);
            wait_for(3, 16'h0002, 1000);
            gap_seen = 16'(n);
            note(6, t);
            set_fault(1'b0);
            wait_for(3, 16'h0000, 3 * t + 4);
            note(1, 16'h0001);
            note(2, 16'h0000);
        end
        arm(2'b10, 3'h7, 3'h0, 16'h0002);
        set_fault(1'b1);
        tick(40);
        // fault never drops, so every attempt keeps the output off
        wait_for(1, 16'h0000, 4);
        note(2, 16'h0000);
        // only the first attempt is counted under continuous retry
        note(3, 16'h0001);
        @(posedge clk);
        cmd_on <= 1'b0;
        tick(6);
        note(1, 16'h0000);
        note(3, 16'h0000);
        set_fault(1'b0);
        @(posedge clk);
        cmd_on <= 1'b1;
        wait_for(1, 16'h0001, 3);
        arm(2'b01, 3'h0, 3'h1, 16'h0002);
        set_fault(1'b1);
        tick(3);
        note(1, 16'h0001);
        wait_for(2, 16'h0001, 6);
        note(1, 16'h0000);
        set_fault(1'b0);
        @(posedge clk);
        clr_bit <= 1'b1;
        @(posedge clk);
        clr_bit <= 1'b0;
        wait_for(1, 16'h0001, 3);
        // short fault gone before the continue time ends: no action
        set_fault(1'b1);
        set_fault(1'b0);
        tick(6);
        note(1, 16'h0001);
        note(2, 16'h0000);
        arm(2'b11, 3'h0, 3'h0, 16'h0002);
        set_fault(1'b1);
        wait_for(1, 16'h0000, 3);
        set_fault(1'b0);
        wait_for(1, 16'h0001, 3);
        arm(2'b00, 3'h0, 3'h0, 16'h0002);
        set_fault(1'b1);
        tick(10);
        note(1, 16'h0001);
        set_fault(1'b0);
        @(posedge clk);
        oth <= 1'b1;
        @(posedge clk);
        oth <= 1'b0;
        wait_for(2, 16'h0001, 3);
        note(1, 16'h0000);
        @(posedge clk);
        bias <= 1'b1;
        wait_for(2, 16'h0000, 3);
        @(posedge clk);
        bias <= 1'b0;
        wait_for(1, 16'h0001, 3);
        tick(2);
        end_of_test();
    end
endmodule : test_fault_retry_and_vout_warn_limits
`default_nettype wire
